// [verilog/rtt_timer.sv]
// Purpose: Reader timeout timer with AXI4-Lite register slave
// Assumes: tx_end and rx_bit are one-cycle pulses synchronous to clk
// Notes:   Zero flag clears when the status register is read
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
module rtt_timer #(
  parameter int ADDR_W = 12
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              tx_end,
  input  wire logic              rx_bit,
  input  wire logic              serial_in_gate_pin,
  input  wire logic              first_auxiliary_pin,
  output logic                   irq,
  output logic                   timer_running_status
);
  import rtt_pkg::*;

  if (ADDR_W < 10) begin : g_chk
    $error("rtt_timer: ADDR_W must be at least 10");
  end

  function automatic logic [7:0] byte_idx(input logic [ADDR_W-1:0] a);
    return a[9:2];
  endfunction

  function automatic logic idx_mapped(input logic [7:0] i);
    return (i >= IDX_MODE && i <= IDX_CNT_LO) ||
           (i >= IDX_CTRL && i <= IDX_IRQMSK);
  endfunction

  logic              awready_q, wready_q, bvalid_q;
  logic              arready_q, rvalid_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [31:0]       rdata_q;
  logic              aw_hold_q, w_hold_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0]        w_data_q;
  logic              w_strb_q;
  logic [7:0]        mode_q, pre_q, rld_hi_q, rld_lo_q;
  logic [7:0]        ctrl_q, msk_q;
  logic [CNT_W-1:0]  count_q;
  logic              running_q, run_sts_q;
  logic [2:0]        bitcnt_q;
  logic [7:0]        irq_sts_q;
  logic              irq_q;
  logic              aw_take, w_take, wr_go, wr_en, ar_take;
  logic [7:0]        wr_idx, rd_idx, rd_val;
  logic              gate_ok, auto_on, multi_on, restart_on;
  logic              sw_start, sw_stop, start_ev, bit_stop;
  logic              tick_cnt, zero_halt, sts_clr;

  rtt_tick_if #(.PW(PRE_W)) tp ();

  rtt_prescaler #(.PW(PRE_W)) u_pre (
    .clk    (clk),
    .resetn (resetn),
    .tp     (tp.div)
  );

  assign awready              = awready_q;
  assign wready               = wready_q;
  assign bvalid               = bvalid_q;
  assign bresp                = bresp_q;
  assign arready              = arready_q;
  assign rvalid               = rvalid_q;
  assign rdata                = rdata_q;
  assign rresp                = rresp_q;
  assign irq                  = irq_q;
  assign timer_running_status = run_sts_q;

  // Write side: address and data are latched independently
  assign aw_take = awvalid && awready_q;
  assign w_take  = wvalid && wready_q;
  assign wr_go   = aw_hold_q && w_hold_q && !bvalid_q;
  assign wr_idx  = byte_idx(aw_addr_q);
  assign wr_en   = wr_go && w_strb_q && idx_mapped(wr_idx);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_addr_q <= awaddr;
      end
      if (w_take) begin
        w_data_q <= wdata[7:0];
        w_strb_q <= wstrb[0];
      end
      aw_hold_q <= aw_take || (aw_hold_q && !wr_go);
      w_hold_q  <= w_take || (w_hold_q && !wr_go);
      awready_q <= !(aw_take || (aw_hold_q && !wr_go));
      wready_q  <= !(w_take || (w_hold_q && !wr_go));
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= idx_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read side: one read in flight, data registered
  assign ar_take = arvalid && arready_q;
  assign rd_idx  = byte_idx(araddr);
  assign sts_clr = ar_take && (rd_idx == IDX_IRQST);

  always_comb begin
    rd_val = 8'h00;
    unique case (rd_idx)
      IDX_MODE:   rd_val = mode_q;
      IDX_PRE:    rd_val = pre_q;
      IDX_RLD_HI: rd_val = rld_hi_q;
      IDX_RLD_LO: rd_val = rld_lo_q;
      IDX_CNT_HI: rd_val = count_q[15:8];
      IDX_CNT_LO: rd_val = count_q[7:0];
      IDX_CTRL:   rd_val = ctrl_q;
      IDX_RUNST:  rd_val = {6'h00, run_sts_q, running_q};
      IDX_IRQST:  rd_val = irq_sts_q;
      IDX_IRQMSK: rd_val = msk_q;
      default:    rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else begin
      arready_q <= !(ar_take || (rvalid_q && !rready));
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q  <= {24'h000000, rd_val};
        rresp_q  <= idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Software registers; stop and start bits are write-one pulses
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q   <= MODE_RST;
      pre_q    <= PRE_RST;
      rld_hi_q <= RLD_RST;
      rld_lo_q <= RLD_RST;
      ctrl_q   <= CTRL_RST;
      msk_q    <= MSK_RST;
    end else if (wr_en) begin
      unique case (wr_idx)
        IDX_MODE:   mode_q <= w_data_q;
        IDX_PRE:    pre_q  <= w_data_q;
        IDX_RLD_HI: rld_hi_q <= w_data_q;
        IDX_RLD_LO: rld_lo_q <= w_data_q;
        IDX_CTRL:   ctrl_q <= w_data_q & 8'h0C;
        IDX_IRQMSK: msk_q  <= w_data_q;
        default:    ;
      endcase
    end
  end

  assign auto_on    = mode_q[MODE_AUTO];
  assign restart_on = mode_q[MODE_RESTART];
  assign multi_on   = ctrl_q[CTRL_MULTI];

  assign tp.prescale = {mode_q[3:0], pre_q};
  assign tp.even     = ctrl_q[CTRL_EVEN];
  assign tp.restart  = start_ev;

  always_comb begin
    gate_ok = 1'b1;
    unique case (mode_q[MODE_GATE +: 2])
      GATE_OFF: gate_ok = 1'b1;
      GATE_SIN: gate_ok = serial_in_gate_pin;
      GATE_AUX: gate_ok = first_auxiliary_pin;
      default:  gate_ok = 1'b1;
    endcase
  end

  assign sw_start = wr_en && (wr_idx == IDX_CTRL) && w_data_q[CTRL_START];
  assign sw_stop  = wr_en && (wr_idx == IDX_CTRL) && w_data_q[CTRL_STOP];
  assign start_ev = !sw_stop && (sw_start || (auto_on && tx_end));
  assign bit_stop = auto_on && !multi_on && running_q && rx_bit &&
                    (bitcnt_q == RX_STOP_BITS - 3'h1);
  assign tick_cnt  = running_q && gate_ok && tp.tick;
  assign zero_halt = tick_cnt && (count_q == '0) && !restart_on &&
                     !sw_stop && !start_ev && !bit_stop;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      running_q <= 1'b0;
    end else if (sw_stop) begin
      running_q <= 1'b0;
    end else if (start_ev) begin
      running_q <= 1'b1;
    end else if (bit_stop || zero_halt) begin
      running_q <= 1'b0;
    end
  end

  // A reload write never touches a running count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= '0;
    end else if (start_ev) begin
      count_q <= {rld_hi_q, rld_lo_q};
    end else if (tick_cnt && !sw_stop && !bit_stop) begin
      if (count_q != '0) begin
        count_q <= count_q - 16'h0001;
      end else if (restart_on) begin
        count_q <= {rld_hi_q, rld_lo_q};
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bitcnt_q <= '0;
    end else if (start_ev) begin
      bitcnt_q <= '0;
    end else if (running_q && rx_bit && bitcnt_q != RX_STOP_BITS) begin
      bitcnt_q <= bitcnt_q + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_sts_q <= 1'b0;
    end else begin
      run_sts_q <= running_q && gate_ok;
    end
  end

  // Set beats the read clear so no zero event is lost
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_sts_q <= '0;
    end else begin
      if (sts_clr) begin
        irq_sts_q <= '0;
      end
      if (zero_halt) begin
        irq_sts_q[IRQ_ZERO] <= 1'b1;
      end
    end
  end

  // One cycle behind the status bits, to keep the output a flop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_sts_q & msk_q);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_start;
    start_ev;
  endsequence

  sequence s_loaded;
    running_q && (count_q == {$past(rld_hi_q), $past(rld_lo_q)});
  endsequence

  a_auto_start: assert property (
    auto_on && tx_end && !sw_stop |=> running_q)
    else $error("auto start missed");
  a_start_load: assert property (
    s_start |=> s_loaded)
    else $error("start did not load reload value");
  a_fifth_stop: assert property (
    bit_stop && !start_ev && !sw_stop |=> !running_q ##1
    (!running_q || $past(start_ev)))
    else $error("fifth bit did not stop timer");
  a_multi_keep: assert property (
    running_q && auto_on && multi_on && !sw_stop && !zero_halt
    |=> running_q)
    else $error("multi-frame timer stopped itself");
  a_proto_ignore: assert property (
    !auto_on && !running_q && tx_end && !sw_start |=> !running_q)
    else $error("protocol started timer");
  a_gate_hold: assert property (
    running_q && !gate_ok && !start_ev |=> $stable(count_q))
    else $error("count moved while gated off");
  a_restart_load: assert property (
    tick_cnt && restart_on && count_q == '0 && !start_ev && !sw_stop &&
    !bit_stop |=> running_q &&
    count_q == {$past(rld_hi_q), $past(rld_lo_q)})
    else $error("restart did not reload");
  a_zero_flag: assert property (
    zero_halt |=> irq_sts_q[IRQ_ZERO] && !running_q ##1
    irq_q == $past(msk_q[IRQ_ZERO]))
    else $error("zero did not raise flag");
  a_reload_hold: assert property (
    running_q && !tp.tick && !start_ev |=> $stable(count_q))
    else $error("count changed without tick");
  a_run_status: assert property (
    ##1 run_sts_q == $past(running_q && gate_ok))
    else $error("running status wrong");
endmodule

// [verilog/rtt_pkg.sv]
// Purpose: Constants of the reader timeout timer
// Assumes: 8-bit registers, one per aligned 32-bit word
// Notes:   Byte address is four times the register index
package rtt_pkg;
  localparam int         REG_W        = 8;
  localparam int         CNT_W        = 16;
  localparam int         PRE_W        = 12;
  localparam logic [7:0] IDX_MODE     = 8'h2A;
  localparam logic [7:0] IDX_PRE      = 8'h2B;
  localparam logic [7:0] IDX_RLD_HI   = 8'h2C;
  localparam logic [7:0] IDX_RLD_LO   = 8'h2D;
  localparam logic [7:0] IDX_CNT_HI   = 8'h2E;
  localparam logic [7:0] IDX_CNT_LO   = 8'h2F;
  localparam logic [7:0] IDX_CTRL     = 8'h3C;
  localparam logic [7:0] IDX_RUNST    = 8'h3D;
  localparam logic [7:0] IDX_IRQST    = 8'h3E;
  localparam logic [7:0] IDX_IRQMSK   = 8'h3F;
  localparam int         MODE_AUTO    = 7;
  localparam int         MODE_GATE    = 5;
  localparam int         MODE_RESTART = 4;
  localparam int         CTRL_STOP    = 0;
  localparam int         CTRL_START   = 1;
  localparam int         CTRL_EVEN    = 2;
  localparam int         CTRL_MULTI   = 3;
  localparam int         IRQ_ZERO     = 0;
  localparam logic [7:0] MODE_RST     = 8'h00;
  localparam logic [7:0] PRE_RST      = 8'h00;
  localparam logic [7:0] RLD_RST      = 8'h00;
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [7:0] MSK_RST      = 8'h00;
  localparam logic [1:0] GATE_OFF     = 2'h0;
  localparam logic [1:0] GATE_SIN     = 2'h1;
  localparam logic [1:0] GATE_AUX     = 2'h2;
  localparam logic [2:0] RX_STOP_BITS = 3'h5;
  localparam int         REF_KHZ      = 13560;
  localparam int         CLK_KHZ      = 125000;
  // Accumulator must hold one reference step past the wrap point
  localparam int         ACC_W        = 18;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage

// [verilog/rtt_tick_if.sv]
// Purpose: Carries prescaler settings down and the timer tick back
// Assumes: One clock domain
// Notes:   restart is a one-cycle pulse on each start event
`timescale 1ns/1ps
interface rtt_tick_if #(parameter int PW = 12);
  logic [PW-1:0] prescale;
  logic          even;
  logic          restart;
  logic          tick;
  modport tmr (output prescale, output even, output restart, input tick);
  modport div (input prescale, input even, input restart, output tick);
endinterface

// [verilog/rtt_prescaler.sv]
// Purpose: 13.56 MHz reference enable and timer tick divider
// Assumes: clk at 125 MHz
// Notes:   Reference rate is fractional, so tick spacing jitters by a cycle
`timescale 1ns/1ps
module rtt_prescaler #(
  parameter int PW = 12
) (
  input  wire logic clk,
  input  wire logic resetn,
  rtt_tick_if.div   tp
);
  import rtt_pkg::*;

  if (PW < 1 || PW > 16) begin : g_chk
    $error("rtt_prescaler: PW out of range");
  end

  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_sum;
  logic             ref_en;
  logic [PW:0]      div_q;
  logic [PW:0]      div_last;
  logic             tick_q;

  assign acc_sum = acc_q + ACC_W'(REF_KHZ);
  assign ref_en  = acc_sum >= ACC_W'(CLK_KHZ);
  assign div_last = {tp.prescale, tp.even};
  assign tp.tick  = tick_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_q <= '0;
    end else if (tp.restart) begin
      acc_q <= '0;
    end else begin
      acc_q <= ref_en ? ACC_W'(acc_sum - ACC_W'(CLK_KHZ)) : acc_sum;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (tp.restart) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= ref_en && (div_q == div_last);
      if (ref_en) begin
        div_q <= (div_q == div_last) ? '0 : (PW+1)'(div_q + 1'b1);
      end
    end
  end
endmodule

// [tb/rtt_timer_bench.sv]
// Purpose: Self-checking bench for the reader timeout timer
// Assumes: AXI4-Lite master at 125 MHz, prescaler kept small for speed
// Notes:   Tick spacing jitters, so period checks carry one tick of slack
`timescale 1ns/1ps
module rtt_timer_bench;
  import rtt_pkg::*;
  logic        clk, resetn;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_q;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp_q;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq, timer_running_status;
  logic        tx_end, rx_bit, serial_in_gate_pin, first_auxiliary_pin;
  int          failures, total_checks;

  rtt_timer #(.ADDR_W(12)) u_dut (
    .clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .tx_end, .rx_bit,
    .serial_in_gate_pin, .first_auxiliary_pin, .irq, .timer_running_status
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: word %h not %h", $time, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: flag %b not %b", $time, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("unexpected at %0t: %0d cycles not in %0d..%0d",
               $time, got, lo, hi);
    end
  endtask

  // Address and data are offered together, each dropped once taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    bit a, w;
    a = 0;
    w = 0;
    awaddr  <= {2'h0, idx, 2'h0};
    wdata   <= {24'h0, val};
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(a && w)) begin
      @(posedge clk);
      if (!a && awready === 1'b1) a = 1;
      if (a) awvalid <= 1'b0;
      if (!w && wready === 1'b1) w = 1;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b1;
    do begin
      @(posedge clk);
    end while (bvalid !== 1'b1);
    resp_q = bresp;
    bready <= 1'b0;
  endtask

  // rready rises only after the address is taken, so back-to-back reads
  // never assign it twice in one step
  task automatic rd(input logic [7:0] idx);
    araddr  <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
    end while (rvalid !== 1'b1);
    rd_q = rdata;
    resp_q = rresp;
    rready <= 1'b0;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic pulse(input bit rx);
    if (rx) rx_bit <= 1'b1;
    else tx_end <= 1'b1;
    @(posedge clk);
    rx_bit <= 1'b0;
    tx_end <= 1'b0;
    cyc(3);
  endtask

  task automatic setup(input logic [7:0] m, input logic [7:0] p,
                       input logic [15:0] r);
    wr(IDX_MODE, m);
    wr(IDX_PRE, p);
    wr(IDX_RLD_HI, r[15:8]);
    wr(IDX_RLD_LO, r[7:0]);
  endtask

  task automatic t_regs();
    rd(IDX_MODE);
    chk_w(rd_q, 32'h0);
    rd(IDX_PRE);
    chk_w(rd_q, 32'h0);
    rd(IDX_RLD_HI);
    chk_w(rd_q, 32'h0);
    wr(IDX_RLD_HI, 8'hA5);
    wr(IDX_RLD_LO, 8'h5A);
    rd(IDX_RLD_HI);
    chk_w(rd_q, 32'hA5);
    rd(IDX_RLD_LO);
    chk_w(rd_q, 32'h5A);
    wr(IDX_CNT_HI, 8'hFF);
    chk_w({30'h0, resp_q}, {30'h0, RESP_OKAY});
    rd(IDX_CNT_HI);
    chk_w(rd_q, 32'h0);
    rd(8'h10);
    chk_w({30'h0, resp_q}, {30'h0, RESP_SLVERR});
    wr(8'h10, 8'h11);
    chk_w({30'h0, resp_q}, {30'h0, RESP_SLVERR});
  endtask

  // Reload N takes N+1 ticks, each (2P+1) or (2P+2) reference periods
  task automatic t_period(input logic [3:0] nib, input logic [7:0] p,
                          input bit ev, input int r);
    int n, per, tot;
    n = 0;
    per = (2 * {nib, p} + 1 + ev) * CLK_KHZ / REF_KHZ;
    tot = (2 * {nib, p} + 1 + ev) * (r + 1) * CLK_KHZ / REF_KHZ;
    setup({4'h0, nib}, p, r[15:0]);
    wr(IDX_CTRL, {5'h0, ev, 2'b10});
    cyc(2);
    while (timer_running_status === 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    chk_n(n, tot - per - 8, tot + per + 8);
    rd(IDX_CNT_HI);
    chk_w(rd_q, 32'h0);
    rd(IDX_CNT_LO);
    chk_w(rd_q, 32'h0);
    rd(IDX_IRQST);
    chk_w(rd_q, 32'h1);
    chk_b(irq, 1'b0);
    rd(IDX_IRQST);
    chk_w(rd_q, 32'h0);
  endtask

  task automatic t_irq();
    wr(IDX_IRQMSK, 8'h01);
    setup(8'h00, 8'h00, 16'h0003);
    wr(IDX_CTRL, 8'h02);
    cyc(60);
    chk_b(irq, 1'b1);
    rd(IDX_IRQST);
    chk_w(rd_q, 32'h1);
    cyc(3);
    chk_b(irq, 1'b0);
    wr(IDX_IRQMSK, 8'h00);
  endtask

  task automatic t_auto();
    setup(8'h80, 8'h00, 16'h03E8);
    pulse(0);
    chk_b(timer_running_status, 1'b1);
    rd(IDX_CNT_HI);
    chk_w(rd_q, 32'h03);
    repeat (4) pulse(1);
    chk_b(timer_running_status, 1'b1);
    pulse(1);
    chk_b(timer_running_status, 1'b0);
  endtask

  task automatic t_manual();
    wr(IDX_MODE, 8'h00);
    pulse(0);
    chk_b(timer_running_status, 1'b0);
    wr(IDX_CTRL, 8'h02);
    repeat (5) pulse(1);
    chk_b(timer_running_status, 1'b1);
    wr(IDX_CTRL, 8'h01);
    cyc(2);
    chk_b(timer_running_status, 1'b0);
  endtask

  task automatic t_multi();
    setup(8'h80, 8'h00, 16'h03E8);
    wr(IDX_CTRL, 8'h08);
    pulse(0);
    repeat (6) pulse(1);
    chk_b(timer_running_status, 1'b1);
    wr(IDX_CTRL, 8'h09);
    cyc(2);
    chk_b(timer_running_status, 1'b0);
    wr(IDX_CTRL, 8'h00);
  endtask

  task automatic t_reload();
    setup(8'h00, 8'h00, 16'h03E8);
    wr(IDX_CTRL, 8'h02);
    wr(IDX_RLD_HI, 8'h10);
    rd(IDX_CNT_HI);
    chk_w(rd_q, 32'h03);
    wr(IDX_CTRL, 8'h01);
    wr(IDX_CTRL, 8'h02);
    rd(IDX_CNT_HI);
    chk_w(rd_q, 32'h10);
    wr(IDX_CTRL, 8'h01);
  endtask

  task automatic t_restart();
    setup(8'h10, 8'h00, 16'h0005);
    wr(IDX_CTRL, 8'h02);
    cyc(300);
    chk_b(timer_running_status, 1'b1);
    rd(IDX_IRQST);
    chk_w(rd_q, 32'h0);
    wr(IDX_CTRL, 8'h01);
  endtask

  // Wrong pin first, then the selected one; codes 00 and 11 run freely
  task automatic t_gate();
    logic [1:0] gs;
    bit         free;
    for (int i = 0; i < 4; i++) begin
      gs = i[1:0];
      free = (gs == GATE_OFF) || (gs == 2'h3);
      serial_in_gate_pin  <= 1'b0;
      first_auxiliary_pin <= 1'b0;
      setup({1'b0, gs, 5'h00}, 8'h00, 16'h00A5);
      wr(IDX_CTRL, 8'h02);
      cyc(40);
      chk_b(timer_running_status, free);
      if (!free) begin
        rd(IDX_CNT_LO);
        chk_w(rd_q, 32'hA5);
        if (gs == GATE_SIN) first_auxiliary_pin <= 1'b1;
        else serial_in_gate_pin <= 1'b1;
        cyc(5);
        chk_b(timer_running_status, 1'b0);
        if (gs == GATE_SIN) serial_in_gate_pin <= 1'b1;
        else first_auxiliary_pin <= 1'b1;
        cyc(40);
        chk_b(timer_running_status, 1'b1);
        rd(IDX_CNT_HI);
        chk_w(rd_q, 32'h0);
        rd(IDX_CNT_LO);
        chk_n(rd_q[7:0], 150, 164);
      end
      wr(IDX_CTRL, 8'h01);
      cyc(2);
    end
  endtask

  // Longest case is near 10k cycles; the limit leaves wide margin
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    wrap_up();
  end

  initial begin
    resetn = 1'b0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {tx_end, rx_bit, serial_in_gate_pin, first_auxiliary_pin} = '0;
    failures = 0;
    total_checks = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    cyc(2);
    t_regs();
    t_period(4'h0, 8'h03, 1'b0, 20);
    t_period(4'h0, 8'h03, 1'b1, 20);
    t_period(4'h1, 8'h00, 1'b0, 1);
    t_irq();
    t_auto();
    t_manual();
    t_multi();
    t_reload();
    t_restart();
    t_gate();
    wrap_up();
  end
endmodule
